// File: sbu_top.sv
`timescale 1ns/1ps
// What this block does
// [RULE_01] Skip when register bit is clear
// [RULE_02] Skip when register bit is set
// [RULE_03] Skip when I/O bit is clear
// [RULE_04] Skip when I/O bit is set
// [RULE_05] Branch k+1 when selected flag set
// [RULE_06] Branch k+1 when selected flag clear
// [RULE_07] Branch k+1 when zero flag set
// [RULE_08] Branch k+1 when zero flag clear
// [RULE_09] Branch k+1 when carry flag set
// [RULE_10] Branch k+1 when carry flag clear
// [RULE_11] Skip costs 2 or 3; untaken costs 1
// [RULE_12] Signed offset; taken 2, untaken 1 cycles
module sbu_top
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   // Decoded instruction and operands, same clock domain
   input  wire sbu_pkg::sbu_req_t req,
   input  wire logic [7:0]       reg_val,
   input  wire logic [7:0]       io_val,
   input  wire logic [7:0]       status_register,
   // Resolution, registered
   output sbu_pkg::sbu_res_t     res,
   output logic                  busy
);

   ////////////////////////////////////////////////////////////////////////////

   // Timing seen from the ports:
   //   edge 0  request taken while the wait counter is zero
   //   edge 1  done pulses, taken, next_pc and cycles settle and hold
   //   edge 1+ busy stands for cycles minus one edges
   // The feeder must not offer a new request while busy is high;
   // such a request is dropped with no sign, to keep the path short.
   // Operands are read in the request cycle only, never latched.
   // Status flags are read here and never written back.

   ////////////////////////////////////////////////////////////////////////////
   // Local state
   ////////////////////////////////////////////////////////////////////////////

   // All state of the unit in one word, so reset and hold live in one place
   typedef struct packed {
      sbu_pkg::sbu_res_t res;      // Last resolution, held until the next one; done pulses for one cycle only
      logic [1:0]        wait_cnt; // Cycles still owed by the last instruction
      logic              busy;     // Kept as a flop so the port is glitch free
   } sbu_state_t;

   sbu_state_t               st_r;
   sbu_state_t               st_nxt;
   logic                     cond_true;
   logic                     accept;
   logic                     is_skip;
   logic [sbu_pkg::PC_W-1:0] fall_pc;
   logic [sbu_pkg::PC_W-1:0] skip_pc;
   logic [sbu_pkg::PC_W-1:0] branch_pc;
   logic [1:0]               skip_cost;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   ////////////////////////////////////////////////////////////////////////////

   // The displacement is widened into the counter, so the counter must be wider
   if (sbu_pkg::PC_W <= 7)
   begin : g_pc_width_check
      $error("Program counter narrower than the branch displacement");
   end

   // Costs must grow with the length of the skipped instruction
   if (sbu_pkg::CYC_THREE <= sbu_pkg::CYC_TWO)
   begin : g_cost_order_check
      $error("Cycle costs out of order for the wait counter");
   end

   // A skip of two words must step further than a skip of one
   if (sbu_pkg::PC_STEP_THREE <= sbu_pkg::PC_STEP_TWO)
   begin : g_step_order_check
      $error("Skip steps out of order");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions
   ////////////////////////////////////////////////////////////////////////////

   // Sign extension of the 7-bit word displacement
   function automatic logic [sbu_pkg::PC_W-1:0] sbu_sext(input logic [6:0] k);
      sbu_sext = {{(sbu_pkg::PC_W-7){k[6]}}, k};
   endfunction : sbu_sext

   // True for the four bit-test skips, which cost by the size of the next word
   function automatic logic sbu_is_skip(input sbu_pkg::sbu_op_t op);
      sbu_is_skip = (op == sbu_pkg::OP_SKIP_REG_BIT_CLEAR) ||
                    (op == sbu_pkg::OP_SKIP_REG_BIT_SET) ||
                    (op == sbu_pkg::OP_SKIP_IO_BIT_CLEAR) ||
                    (op == sbu_pkg::OP_SKIP_IO_BIT_SET);
   endfunction : sbu_is_skip

   // Step past the skipped instruction: one word or two
   function automatic logic [sbu_pkg::PC_W-1:0] sbu_skip_step(input logic two_words);
      if (two_words)
      begin
         sbu_skip_step = sbu_pkg::PC_STEP_THREE;
      end
      else
      begin
         sbu_skip_step = sbu_pkg::PC_STEP_TWO;
      end
   endfunction : sbu_skip_step

   // Cost of a taken skip, one cycle more for a two-word victim
   function automatic logic [1:0] sbu_skip_cost(input logic two_words);
      if (two_words)
      begin
         sbu_skip_cost = sbu_pkg::CYC_THREE;
      end
      else
      begin
         sbu_skip_cost = sbu_pkg::CYC_TWO;
      end
   endfunction : sbu_skip_cost

   ////////////////////////////////////////////////////////////////////////////
   // Condition evaluation
   ////////////////////////////////////////////////////////////////////////////

   // Bit and flag selection lives apart so the polarity table stays in one place
   sbu_cond u_cond
   (
      .op              (req.op),
      .bit_sel         (req.bit_sel),
      .reg_val         (reg_val),
      .io_val          (io_val),
      .status_register (status_register),
      .cond_true       (cond_true)
   );

   ////////////////////////////////////////////////////////////////////////////

   ////////////////////////////////////////////////////////////////////////////
   // Resolution
   ////////////////////////////////////////////////////////////////////////////

   // Candidate targets, worked out every cycle whether or not a request stands.
   // Kept apart from the state update so each sum has an adder of its own.
   always_comb
   begin
      accept    = req.valid && (st_r.wait_cnt == sbu_pkg::CYC_ZERO);
      is_skip   = sbu_is_skip(req.op);
      fall_pc   = req.pc + sbu_pkg::PC_STEP_ONE;                 // see [RULE_11] [RULE_12]
      skip_pc   = req.pc + sbu_skip_step(req.next_two_words);    // see [RULE_11]
      skip_cost = sbu_skip_cost(req.next_two_words);             // see [RULE_11]
      // Wraps modulo the counter width, as the core's PC does
      branch_pc = req.pc + sbu_sext(req.offset) + sbu_pkg::PC_STEP_ONE; // see [RULE_12]
   end

   // Resolve in one cycle, then hold busy for the remaining cycles.
   // Requests while busy are dropped silently; the feeder must wait.
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.res.done = 1'b0;
      if (st_r.wait_cnt != sbu_pkg::CYC_ZERO)
      begin
         // Count down the cycles owed by the last instruction
         st_nxt.wait_cnt = st_r.wait_cnt - sbu_pkg::CYC_ONE;
      end
      else if (accept)
      begin
         st_nxt.res.done  = 1'b1;
         st_nxt.res.taken = cond_true;
         if (!cond_true)
         begin
            // Not taken: carry on with the next word, one cycle
            st_nxt.res.next_pc = fall_pc;                       // see [RULE_11] [RULE_12]
            st_nxt.res.cycles  = sbu_pkg::CYC_ONE;
         end
         else if (is_skip)
         begin
            // Skip length follows the size of the skipped instruction
            st_nxt.res.next_pc = skip_pc;                       // see [RULE_11]
            st_nxt.res.cycles  = skip_cost;
         end
         else
         begin
            // Taken branch: relative target, two cycles
            st_nxt.res.next_pc = branch_pc;                     // see [RULE_12]
            st_nxt.res.cycles  = sbu_pkg::CYC_TWO;
         end
         st_nxt.wait_cnt = st_nxt.res.cycles - sbu_pkg::CYC_ONE;
      end
      // Busy follows the next counter value so the port is a plain flop
      st_nxt.busy = (st_nxt.wait_cnt != sbu_pkg::CYC_ZERO);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and outputs
   ////////////////////////////////////////////////////////////////////////////

   // State register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Ports come straight from the state flops
   assign res  = st_r.res;
   assign busy = st_r.busy;

endmodule : sbu_top

// File: sbu_pkg.sv
package sbu_pkg;

   // Program counter width in words
   localparam int PC_W = 16;

   // Status register flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;

   // Offsets and cycle counts
   localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
   localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
   localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [1:0] CYC_ZERO = 2'h0;

   // Instruction selector
   typedef enum logic [3:0] {
      OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET,
      OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_ON_EQUAL,
      OP_BRANCH_ON_NOT_EQUAL,
      OP_BRANCH_ON_CARRY_SET,
      OP_BRANCH_ON_CARRY_CLEAR
   } sbu_op_t;

   // Decoded request from fetch and decode
   typedef struct packed {
      logic           valid;
      sbu_op_t        op;
      logic [2:0]     bit_sel;
      logic [6:0]     offset;
      logic [PC_W-1:0] pc;
      logic           next_two_words;
   } sbu_req_t;

   // Resolution handed back to the program counter
   typedef struct packed {
      logic           done;
      logic           taken;
      logic [PC_W-1:0] next_pc;
      logic [1:0]     cycles;
   } sbu_res_t;

endpackage : sbu_pkg

// File: sbu_cond.sv
`timescale 1ns/1ps
// Condition evaluation: picks the tested bit and compares its polarity
module sbu_cond
(
   // Selection
   input  wire sbu_pkg::sbu_op_t op,
   input  wire logic [2:0]       bit_sel,
   // Operands
   input  wire logic [7:0]       reg_val,
   input  wire logic [7:0]       io_val,
   input  wire logic [7:0]       status_register,
   // Result
   output logic                  cond_true
);

   // One mux per operand source; polarity from the instruction
   always_comb
   begin
      unique case (op)
         sbu_pkg::OP_SKIP_REG_BIT_CLEAR:    cond_true = ~reg_val[bit_sel];         // see [RULE_01]
         sbu_pkg::OP_SKIP_REG_BIT_SET:      cond_true = reg_val[bit_sel];          // see [RULE_02]
         sbu_pkg::OP_SKIP_IO_BIT_CLEAR:     cond_true = ~io_val[bit_sel];          // see [RULE_03]
         sbu_pkg::OP_SKIP_IO_BIT_SET:       cond_true = io_val[bit_sel];           // see [RULE_04]
         sbu_pkg::OP_BRANCH_FLAG_SET:       cond_true = status_register[bit_sel];  // see [RULE_05]
         sbu_pkg::OP_BRANCH_FLAG_CLEAR:     cond_true = ~status_register[bit_sel]; // see [RULE_06]
         sbu_pkg::OP_BRANCH_ON_EQUAL:       cond_true = status_register[sbu_pkg::FLAG_Z];  // see [RULE_07]
         sbu_pkg::OP_BRANCH_ON_NOT_EQUAL:   cond_true = ~status_register[sbu_pkg::FLAG_Z]; // see [RULE_08]
         sbu_pkg::OP_BRANCH_ON_CARRY_SET:   cond_true = status_register[sbu_pkg::FLAG_C];  // see [RULE_09]
         sbu_pkg::OP_BRANCH_ON_CARRY_CLEAR: cond_true = ~status_register[sbu_pkg::FLAG_C]; // see [RULE_10]
         default:                           cond_true = 1'b0;
      endcase
   end

endmodule : sbu_cond

// File: sbu_properties.sv
`timescale 1ns/1ps
// Timing and value checks on the resolution, seen only from the top ports
module sbu_properties
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              arst_n,
   // Request side
   input wire sbu_pkg::sbu_req_t req,
   input wire logic [7:0]        reg_val,
   input wire logic [7:0]        io_val,
   input wire logic [7:0]        status_register,
   // Result side
   input wire sbu_pkg::sbu_res_t res,
   input wire logic              busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // A request only counts when the unit is idle; refused ones leave no trace
   wire acc = req.valid && !busy;
   wire br  = req.op >= sbu_pkg::OP_BRANCH_FLAG_SET;
   sequence busy_two; busy [*2] ##1 !busy; endsequence
   done_one_a: assert property (acc |=> res.done) else $error("missing done");
   no_spur_a: assert property (!acc |=> !res.done) else $error("stray done");
   untaken_cost_a: assert property (res.done && !res.taken |-> res.cycles == 2'h1
      && res.next_pc == $past(req.pc) + 16'h0001) else $error("bad fall through");
   skip_cost_a: assert property (acc && !br |=> !res.taken
      || res.cycles == 2'h2 + $past(req.next_two_words)) else $error("bad skip cost");
   branch_tgt_a: assert property (acc && br |=> !res.taken || res.cycles == 2'h2
      && res.next_pc == $past(req.pc) + {{9{$past(req.offset[6])}}, $past(req.offset)}
      + 16'h0001) else $error("bad branch target");
   busy_three_a: assert property (res.done && res.cycles == 2'h3 |-> busy_two)
      else $error("bad busy length");
   equal_flag_a: assert property (acc && req.op == sbu_pkg::OP_BRANCH_ON_EQUAL
      |=> res.taken == $past(status_register[sbu_pkg::FLAG_Z])) else $error("bad equal");
   io_set_a: assert property (acc && req.op == sbu_pkg::OP_SKIP_IO_BIT_SET
      |=> res.taken == $past(io_val[req.bit_sel])) else $error("bad io skip");
   reg_clear_a: assert property (acc && req.op == sbu_pkg::OP_SKIP_REG_BIT_CLEAR
      |=> res.taken == !$past(reg_val[req.bit_sel])) else $error("bad reg skip");
endmodule : sbu_properties
////////////////////////////////////////////////////////////////////////////////
bind sbu_top sbu_properties u_props (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
   .reg_val(reg_val), .io_val(io_val), .status_register(status_register), .res(res), .busy(busy));

// File: skip_and_branch_unit_test.sv
`timescale 1ns/1ps
// Drives decoded requests and judges each resolution
module skip_and_branch_unit_test;
   logic              sys_clk    = 1'b0;
   logic              arst_n     = 1'b0;
   sbu_pkg::sbu_req_t req        = '0;
   logic [7:0]        v          = 8'h00;
   sbu_pkg::sbu_res_t res;
   logic              busy;
   int                num_errors = 0;
   int                checked    = 0;
   int                ticks      = 0;
   always #10 sys_clk = ~sys_clk;
   // The I/O operand is the inverse so a swapped source is caught
   sbu_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .reg_val(v), .io_val(~v),
      .status_register(v), .res(res), .busy(busy));
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, far above the few dozen cycles the tests need
   always @(posedge sys_clk)
   begin
      ticks++;
      if (ticks == 2000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One request, result checked one cycle later, then busy waited out
   task automatic run(input logic [3:0] o, input logic [2:0] b, input logic [6:0] k,
      input logic [15:0] pc, input logic w, input logic [7:0] val, input logic t,
      input logic [15:0] npc, input logic [1:0] c);
      @(negedge sys_clk);
      req = '{1'b1, sbu_pkg::sbu_op_t'(o), b, k, pc, w};
      v = val;
      @(negedge sys_clk);
      req.valid = 1'b0;
      chk({res.done, res.taken, res.next_pc, res.cycles}, {1'b1, t, npc, c});
      while (busy) @(negedge sys_clk);
   endtask : run
   task automatic t_skips;
      run(4'h0, 3'h3, 7'h00, 16'h0100, 1'b1, 8'hf7, 1'b1, 16'h0103, 2'h3);
      run(4'h1, 3'h3, 7'h00, 16'h0200, 1'b0, 8'h08, 1'b1, 16'h0202, 2'h2);
      run(4'h1, 3'h3, 7'h00, 16'hffff, 1'b0, 8'hf7, 1'b0, 16'h0000, 2'h1);
      run(4'h2, 3'h7, 7'h00, 16'h0300, 1'b0, 8'h80, 1'b1, 16'h0302, 2'h2);
      run(4'h3, 3'h0, 7'h00, 16'h0400, 1'b1, 8'hfe, 1'b1, 16'h0403, 2'h3);
      $display("skips done");
   endtask : t_skips
   task automatic t_branches;
      run(4'h4, 3'h5, 7'h7e, 16'h0010, 1'b0, 8'h20, 1'b1, 16'h000f, 2'h2);
      run(4'h5, 3'h5, 7'h7e, 16'h0010, 1'b0, 8'h20, 1'b0, 16'h0011, 2'h1);
      run(4'h6, 3'h0, 7'h3f, 16'h0010, 1'b0, 8'h02, 1'b1, 16'h0050, 2'h2);
      run(4'h7, 3'h0, 7'h3f, 16'h0010, 1'b0, 8'h02, 1'b0, 16'h0011, 2'h1);
      run(4'h8, 3'h0, 7'h40, 16'h0100, 1'b0, 8'h01, 1'b1, 16'h00c1, 2'h2);
      run(4'h9, 3'h0, 7'h7f, 16'h0000, 1'b0, 8'h00, 1'b1, 16'h0000, 2'h2);
      $display("branches done");
   endtask : t_branches
   task automatic report_and_stop;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      t_skips();
      t_branches();
      report_and_stop();
   end
endmodule : skip_and_branch_unit_test
